/* rtl/lcft_pkg.sv */
// Constants and carrier types for the display frame timing block.
// Assumes one 200 MHz clock; oscillator clocks arrive as sampled levels.
package lcft_pkg;

  localparam int LCFT_MAIN_BASE_EXP = 11;
  localparam int LCFT_SUB_BASE_EXP = 6;
  localparam int LCFT_PRE_W = 18;

  // Mode register field positions
  localparam int LCFT_CK_LSB = 0;
  localparam int LCFT_TY_LSB = 4;
  localparam int LCFT_EN_BIT = 7;
  localparam int LCFT_SUBSEL_BIT = 3;
  localparam logic [7:0] LCFT_MODE_RST = 8'h00;

  typedef enum logic [1:0] {
    LCFT_DUTY_QUARTER = 2'b00,
    LCFT_DUTY_THIRD = 2'b01,
    LCFT_DUTY_HALF = 2'b10,
    LCFT_DUTY_STATIC = 2'b11
  } lcft_duty_type;

  // Analog switch controls for the on-chip bias string
  typedef struct packed {
    logic top_to_mid_lo;
    logic mid_to_low_lo;
    logic low_to_gnd_lo;
    logic top_to_mid_hi;
    logic mid_to_low_hi;
    logic low_to_gnd_hi;
  } lcft_bias_sw_type;

  // Per-step drive timing towards the common and segment drivers
  typedef struct packed {
    logic running;
    logic [3:0] com_active;
    logic [1:0] step;
    logic frame_start;
  } lcft_timing_type;

  typedef struct packed {
    logic [2:0] main_sync;
    logic [2:0] sub_sync;
    logic [LCFT_PRE_W-1:0] pre_cnt;
    logic drv_clk;
    logic [1:0] step;
    logic frame_start;
  } lcft_state_type;

  localparam logic [LCFT_PRE_W-1:0] LCFT_PRE_RST = 18'h00000;
  localparam logic [1:0] LCFT_STEP_RST = 2'h0;

endpackage

/* rtl/lcft_frame_timing.sv */
// Display drive clock prescaler, duty sequencer and bias string control.
// Assumes oscillator clocks are slow next to clk and are synchronised here.
// Assumes the mode and divider controls are driven from logic on clk.
//
// Overview of operation
// RULE1: Drive clock is main or sub oscillator through a prescaler.
// RULE2: Prescaler choice comes from mode register bits three to zero.
// RULE3: Duty from bits five and four; frame is drive clock over steps.
// RULE4: Step timing picks which bias level each common and segment gets.
// RULE5: Low option connects 10 k elements, high option 100 k elements.
// RULE6: Elements sit top-mid, mid-low and low-ground when connected.
// RULE7: With the on-chip string, the three bias pins may become ports.
// RULE8: Duty 00 quarter, 01 third, 10 half, 11 static.
// RULE9: 0xxx main over 2^11..2^18; 1x00..1x11 sub over 2^6..2^9.
// RULE10: Timing runs only while mode bit seven is one.
// RULE11: Resistance select zero picks low elements, one picks high.
// RULE12: Prescaler and step counter held clear while disabled.
`timescale 1ns/1ps
module lcft_frame_timing
  import lcft_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic main_osc_clock,
  input wire logic sub_osc_clock,
  input wire logic [7:0] display_mode_ctrl_one,
  input wire logic divider_resistance_sel,
  input wire logic divider_connect_sel,
  output lcft_timing_type timing,
  output logic drive_clock,
  output lcft_bias_sw_type bias_sw,
  output logic bias_pins_free
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  // Refuse constants the tap and field logic cannot serve
  if (LCFT_PRE_W < LCFT_MAIN_BASE_EXP + 7) begin : g_main_fit
    $error("prescaler too narrow for the slowest main tap");
  end
  if (LCFT_PRE_W < LCFT_SUB_BASE_EXP + 3) begin : g_sub_fit
    $error("prescaler too narrow for the slowest sub tap");
  end
  if (LCFT_SUB_BASE_EXP < 1) begin : g_sub_base
    $error("sub tap base must be at least one");
  end
  if (LCFT_MAIN_BASE_EXP + 6 > 31) begin : g_tap_range
    $error("main tap beyond the five bit tap index");
  end
  if (LCFT_CK_LSB + 4 > LCFT_TY_LSB) begin : g_field_order
    $error("clock field overlaps the duty field");
  end
  if (LCFT_TY_LSB + 2 > LCFT_EN_BIT || LCFT_EN_BIT > 7) begin : g_run_bit
    $error("run bit misplaced in the mode register");
  end
  if (LCFT_SUBSEL_BIT != 3) begin : g_src_bit
    $error("source bit must be the top bit of the clock field");
  end
  if (LCFT_MODE_RST[LCFT_EN_BIT] != 1'b0) begin : g_rst_stop
    $error("mode register must reset with the driver stopped");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  // Whole block state, one register copy and its next value
  lcft_state_type st_ff;
  lcft_state_type nxt_st;

  logic run_en;
  logic sub_sel;
  logic [3:0] drive_clock_divider_sel;
  lcft_duty_type duty_sel;
  logic [4:0] tap;
  logic osc_edge;
  logic tap_edge;
  logic [1:0] last_step;
  logic [3:0] com_hot;
  logic [2:0] lo_close;
  logic [2:0] hi_close;

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // Steps in one frame minus one
  function automatic logic [1:0] last_of(lcft_duty_type d);
    case (d)
      LCFT_DUTY_QUARTER: last_of = 2'h3;
      LCFT_DUTY_THIRD: last_of = 2'h2;
      LCFT_DUTY_HALF: last_of = 2'h1;
      default: last_of = 2'h0;
    endcase
  endfunction

  // Prescaler bit k toggles at source/2^(k+1)
  function automatic logic [4:0] tap_of(logic [3:0] sel);
    if (sel[LCFT_SUBSEL_BIT]) begin
      tap_of = 5'(LCFT_SUB_BASE_EXP - 1) + {3'h0, sel[1:0]};
    end else begin
      tap_of = 5'(LCFT_MAIN_BASE_EXP - 1) + {2'h0, sel[2:0]};
    end
  endfunction

  // Rising edge between the second and third sync stages
  function automatic logic rise_of(logic [2:0] sync);
    rise_of = sync[1] & ~sync[2];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode

  // Fields may change at any time; run acts at once, clock select at the next oscillator rise, duty at the next drive rise
  assign run_en = display_mode_ctrl_one[LCFT_EN_BIT]; // see RULE10
  assign drive_clock_divider_sel =
    display_mode_ctrl_one[LCFT_CK_LSB +: 4]; // see RULE2
  assign duty_sel =
    lcft_duty_type'(display_mode_ctrl_one[LCFT_TY_LSB +: 2]); // see RULE3
  assign sub_sel = drive_clock_divider_sel[LCFT_SUBSEL_BIT];
  assign last_step = last_of(duty_sel); // see RULE8
  // Bit two of the clock field is ignored for the sub source
  assign tap = tap_of(drive_clock_divider_sel); // see RULE9

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler and frame step counter

  // The prescaler is shared by both sources and survives a source change,
  // so the first drive period after a switch may be short.
  // A step already past a newly chosen last step wraps at the next rise.
  always_comb begin
    nxt_st = st_ff;
    // Two sync stages; the third stage only marks the edge
    nxt_st.main_sync = {st_ff.main_sync[1:0], main_osc_clock};
    nxt_st.sub_sync = {st_ff.sub_sync[1:0], sub_osc_clock};
    nxt_st.frame_start = 1'b0;

    // Rising edge of the selected oscillator, after two sync stages
    if (sub_sel) begin // see RULE1
      osc_edge = rise_of(st_ff.sub_sync);
    end else begin
      osc_edge = rise_of(st_ff.main_sync);
    end
    tap_edge = 1'b0;

    // Cleared while stopped so that a start opens on the first common
    if (!run_en) begin // see RULE12
      nxt_st.pre_cnt = LCFT_PRE_RST;
      nxt_st.drv_clk = 1'b0;
      nxt_st.step = LCFT_STEP_RST;
    end else if (osc_edge) begin
      // Counter wraps freely; only the selected tap is watched
      nxt_st.pre_cnt = st_ff.pre_cnt + 18'h00001;
      nxt_st.drv_clk = nxt_st.pre_cnt[tap];
      tap_edge = nxt_st.drv_clk & ~st_ff.drv_clk;
      if (tap_edge) begin // see RULE3
        if (st_ff.step >= last_step) begin
          nxt_st.step = LCFT_STEP_RST;
          nxt_st.frame_start = 1'b1;
        end else begin
          nxt_st.step = st_ff.step + 2'h1;
        end
      end
    end
  end

  // Synchronous reset; combinational outputs follow their inputs meanwhile
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= '{main_sync: 3'h0,
                 sub_sync: 3'h0,
                 pre_cnt: LCFT_PRE_RST,
                 drv_clk: 1'b0,
                 step: LCFT_STEP_RST,
                 frame_start: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Common phase and timing outputs

  // One common phase per step; none while stopped
  // Static drive keeps the step at zero, so only the first common runs
  for (genvar c = 0; c < 4; c++) begin : g_common
    assign com_hot[c] = run_en & (st_ff.step == 2'(c)); // see RULE4
  end

  // Drive clock and step come straight from flip-flops
  assign drive_clock = st_ff.drv_clk;

  always_comb begin
    timing.running = run_en;
    timing.step = st_ff.step;
    timing.frame_start = st_ff.frame_start;
    timing.com_active = com_hot;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bias divider string

  // Index 2 top-mid, 1 mid-low, 0 low-ground
  // Never both groups at once: that would shunt the chosen resistance
  for (genvar e = 0; e < 3; e++) begin : g_element
    assign lo_close[e] =
      divider_connect_sel & ~divider_resistance_sel; // see RULE5 see RULE11
    assign hi_close[e] =
      divider_connect_sel & divider_resistance_sel; // see RULE5 see RULE11
  end

  always_comb begin // see RULE6
    bias_sw.top_to_mid_lo = lo_close[2];
    bias_sw.mid_to_low_lo = lo_close[1];
    bias_sw.low_to_gnd_lo = lo_close[0];
    bias_sw.top_to_mid_hi = hi_close[2];
    bias_sw.mid_to_low_hi = hi_close[1];
    bias_sw.low_to_gnd_hi = hi_close[0];
  end

  // Bias pins may return to port use while the string is connected
  assign bias_pins_free = divider_connect_sel; // see RULE7

endmodule

/* sim/lcft_asserts.sv */
// Checker on the frame timing ports.
// Assumes a bind into lcft_frame_timing.
`timescale 1ns/1ps
module lcft_asserts
  import lcft_pkg::*;
(
  input logic clk,
  input logic rst_n,
  input logic [7:0] display_mode_ctrl_one,
  input logic divider_resistance_sel,
  input logic divider_connect_sel,
  input lcft_timing_type timing,
  input logic drive_clock,
  input lcft_bias_sw_type bias_sw,
  input logic bias_pins_free
);
  wire [7:0] m = display_mode_ctrl_one;
  wire c = divider_connect_sel;
  wire r = divider_resistance_sel;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_stop_clear: assert property (!m[7] |=>
    !drive_clock && timing.step == 2'h0) else $error("not cleared");
  a_run_copy: assert property (timing.running == m[7])
    else $error("run flag");
  a_com_phase: assert property (m[7] |->
    timing.com_active == 4'h1 << timing.step) else $error("phase");
  a_frame_once: assert property (timing.frame_start |=>
    !timing.frame_start) else $error("pulse");
  a_frame_step: assert property (timing.frame_start |->
    timing.step == 2'h0) else $error("wrap");
  a_static_hold: assert property (m[5:4] == 2'h3 &&
    $stable(m) && timing.step == 2'h0 |=> timing.step == 2'h0)
    else $error("static");
  a_bias_string: assert property (bias_sw ==
    {{3{c && !r}}, {3{c && r}}}) else $error("bias");
  a_pins_free: assert property (bias_pins_free == c)
    else $error("pins");
endmodule
bind lcft_frame_timing lcft_asserts lcft_asserts_inst (.clk, .rst_n,
  .display_mode_ctrl_one, .divider_resistance_sel, .divider_connect_sel,
  .timing, .drive_clock, .bias_sw, .bias_pins_free);

/* sim/lcft_panel.sv */
// Panel stand-in: counts frames.
// Assumes timing on clk.
`timescale 1ns/1ps
module lcft_panel
  import lcft_pkg::*;
(
  input logic clk,
  input lcft_timing_type timing,
  output int frames = 0
);
  always @(posedge clk) begin
    frames <= frames + int'(timing.frame_start === 1'b1);
  end
endmodule

/* sim/tb_top.sv */
// Bench for the frame timing block.
// Assumes the panel stand-in and checker.
`timescale 1ns/1ps
module tb_top;
  import lcft_pkg::*;
  logic clk = 0;
  logic rst_n = 0;
  logic mn = 0;
  logic sb = 0;
  logic [7:0] md = 8'h00;
  logic [1:0] cr = 2'h0;
  lcft_timing_type tm;
  logic dc;
  lcft_bias_sw_type sw;
  logic pf;
  int frames;
  int bad_count = 0;
  int n_compared = 0;
  always #2.5 clk = ~clk;
  lcft_frame_timing lcft_frame_timing_inst (.clk, .rst_n,
    .main_osc_clock(mn), .sub_osc_clock(sb), .display_mode_ctrl_one(md),
    .divider_resistance_sel(cr[0]), .divider_connect_sel(cr[1]),
    .timing(tm), .drive_clock(dc), .bias_sw(sw), .bias_pins_free(pf));
  lcft_panel lcft_panel_inst (.clk, .timing(tm), .frames);
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic run(logic [7:0] m, bit s, int n, logic [7:0] f, logic d,
    logic [1:0] st);
    int f0;
    @(posedge clk);
    md <= 8'h00;
    repeat (2) @(posedge clk);
    md <= m;
    @(negedge clk);
    chk({dc, tm.step}, 32'h0);
    chk(tm.com_active, 32'h1);
    f0 = frames;
    repeat (n) begin
      @(posedge clk);
      sb <= s;
      mn <= !s;
      repeat (4) @(posedge clk);
      sb <= 1'b0;
      mn <= 1'b0;
      repeat (3) @(posedge clk);
    end
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk(frames - f0, f);
    chk(dc, d);
    chk(tm.step, st);
    chk(tm.com_active, 32'h1 << st);
    chk(tm.running, 32'h1);
  endtask
  task automatic t_bias();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      cr <= i[1:0];
      @(negedge clk);
      chk(sw, {2'h0, {3{i == 2}}, {3{i == 3}}});
      chk(pf, i[1]);
    end
  endtask
  task automatic t_div();
    run(8'h80, 1'b0, 1023, 8'h00, 1'b0, 2'h0);
    run(8'h80, 1'b0, 1024, 8'h00, 1'b1, 2'h1);
    run(8'hB8, 1'b0, 64, 8'h00, 1'b0, 2'h0);
    run(8'h89, 1'b1, 64, 8'h00, 1'b1, 2'h1);
  endtask
  task automatic t_duty();
    logic [7:0] fr [4] = '{8'h01, 8'h01, 8'h02, 8'h05};
    logic [1:0] sp [4] = '{2'h1, 2'h2, 2'h1, 2'h0};
    for (int d = 0; d < 4; d++) begin
      run({2'h2, d[1:0], 4'hC}, 1'b1, 288, fr[d], 1'b1, sp[d]);
    end
  endtask
  task automatic t_reset();
    run(8'h8C, 1'b1, 32, 8'h00, 1'b1, 2'h1);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk({dc, tm.step, tm.frame_start}, 32'h0);
    chk(tm.com_active, 32'h1);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_bias();
    t_div();
    t_duty();
    t_reset();
    conclude();
  end
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    conclude();
  end
endmodule
